// *** rtl/qp_defs.svh ***
// Purpose: Shared constants of the quad pot serial link and its controller.
// Assumes: 125 MHz system clock.
// Notes: Included by bare name; definitions only.
`ifndef QP_DEFS_SVH
`define QP_DEFS_SVH

// ----------------------------------------------------------------------
// Frame coding
// ----------------------------------------------------------------------
// Device-type bits of the address byte; the value is arbitrary.
`define QP_DEV_TYPE 6'h2B
`define QP_OP_WDR 4'hC
`define QP_OP_D2W 4'hD
`define QP_OP_W2D 4'hE
`define QP_OP_GD2W 4'h1
`define QP_OP_GW2D 4'h8
`define QP_OP_STEP 4'h2
`define QP_INS_STATUS 8'h51
`define QP_POTS 4
`define QP_WCR_RST 6'h00
`define QP_DR_RST 6'h00
`define QP_WIPER_MAX 6'h3F

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Write-cycle time in ns; plain default, no figure is given.
`define QP_TWR_NS 32'h004C_4B40
`define QP_CLK_NS 32'h0000_0008
// Half period of the serial clock in system cycles (160 ns period).
`define QP_SCK_HALF 8'h0A
// Chip-select high time between frames in system cycles.
`define QP_CS_GAP 8'h10

// ----------------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------------
`define QP_REG_CMD 8'h00
`define QP_REG_STAT 8'h04
`define QP_CMD_INS 7:0
`define QP_CMD_DATA 15:8
`define QP_CMD_CHIP 17:16
`define QP_CMD_EXTRA 27:24
`define QP_RESP_OKAY 2'h0
`define QP_RESP_SLVERR 2'h2

`endif

// *** rtl/qp_host.sv ***
// Purpose: Serial link master for the quad pot, ordered over AXI4-Lite.
// Assumes: 125 MHz clock; link clock made here by a divider.
// Notes: One frame at a time; software polls the busy bit.
`include "qp_defs.svh"
`default_nettype none
module qp_host
    import qp_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    qp_link_if.host link
);
    // ------------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------------
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] cmd;
    logic go;
    logic [7:0] rx;
    qp_host_state_t state;

    wire logic busy = go || state != HS_IDLE;
    wire logic wr_fire = !o_awready && !o_wready && !o_bvalid;
    wire logic wr_cmd = aw_addr == `QP_REG_CMD;
    // A command written while a frame runs is refused, not queued.
    wire logic wr_ok = wr_cmd && !busy;
    wire logic [31:0] stat = {16'h0000, rx, 7'h00, busy};
    wire logic rd_cmd = i_araddr == `QP_REG_CMD;
    wire logic rd_stat = i_araddr == `QP_REG_STAT;
    wire logic [31:0] rd_mux = rd_cmd ? cmd : rd_stat ? stat : 32'h0000_0000;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= `QP_RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            go <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                o_awready <= 1'b0;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                o_wready <= 1'b0;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            go <= wr_fire && wr_ok;
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? `QP_RESP_OKAY : `QP_RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_cmd
        always_ff @(posedge i_clk_sys or negedge i_rstn) begin
            if (!i_rstn) begin
                cmd[b * 8 +: 8] <= 8'h00;
            end else if (wr_fire && wr_ok && w_strb[b]) begin
                cmd[b * 8 +: 8] <= w_data[b * 8 +: 8];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `QP_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_mux;
            o_rresp <= (rd_cmd || rd_stat) ? `QP_RESP_OKAY : `QP_RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Link master
    // ------------------------------------------------------------------
    logic [7:0] hc;
    logic [4:0] bc;
    logic [4:0] nbits;
    logic [23:0] sh;
    logic so_s1;
    logic so_s2;

    wire logic hc_done = hc == `QP_SCK_HALF - 8'h01;
    wire logic gap_done = hc == `QP_CS_GAP - 8'h01;
    wire logic [3:0] extra = cmd[`QP_CMD_EXTRA] > 4'h8 ? 4'h8 : cmd[`QP_CMD_EXTRA];
    // Address byte, instruction byte, then up to eight data or step bits.
    wire logic [23:0] frame = {`QP_DEV_TYPE, cmd[`QP_CMD_CHIP], cmd[`QP_CMD_INS],
        cmd[`QP_CMD_DATA]}; // [R01] [R02] [R03] [R04] [R05] [R06] [R07] [R11]

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= HS_IDLE;
            hc <= 8'h00;
            bc <= 5'h00;
            nbits <= 5'h00;
            sh <= 24'h00_0000;
            rx <= 8'h00;
            so_s1 <= 1'b0;
            so_s2 <= 1'b0;
            link.cs_n <= 1'b1;
            link.sck <= 1'b0;
            link.si <= 1'b0;
        end else begin
            so_s1 <= link.so;
            so_s2 <= so_s1;
            hc <= (state == HS_IDLE || hc_done && state != HS_GAP || gap_done)
                ? 8'h00 : hc + 8'h01;
            case (state)
                HS_IDLE: begin
                    if (go) begin
                        link.cs_n <= 1'b0;
                        link.si <= frame[23];
                        sh <= {frame[22:0], 1'b0};
                        bc <= 5'h00;
                        nbits <= 5'h10 + {1'b0, extra};
                        state <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (hc_done) begin
                        link.sck <= 1'b1;
                        state <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (hc_done) begin
                        rx <= {rx[6:0], so_s2}; // [R02]
                        link.sck <= 1'b0;
                        if (bc == nbits - 5'h01) begin
                            state <= HS_TRAIL;
                        end else begin
                            bc <= bc + 5'h01;
                            link.si <= sh[23];
                            sh <= {sh[22:0], 1'b0};
                            state <= HS_LOW;
                        end
                    end
                end
                HS_TRAIL: begin
                    if (hc_done) begin
                        link.cs_n <= 1'b1; // [R08]
                        state <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    if (gap_done) begin
                        state <= HS_IDLE;
                    end
                end
                default: state <= HS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/qp_link_if.sv ***
// Purpose: Serial link between the pot controller and the pot device.
// Assumes: Mode 0 signalling, clock idles low.
// Notes: so is meaningful only while so_oe is high.
`default_nettype none
interface qp_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface
`default_nettype wire

// *** rtl/qp_pkg.sv ***
// Purpose: Types shared by both ends of the quad pot link.
// Assumes: Nothing.
// Notes: Constants live in qp_defs.svh.
`default_nettype none
package qp_pkg;
    typedef logic [5:0] qp_wiper_t;
    typedef enum logic [2:0] {
        DS_ADDR, DS_INSTR, DS_WDATA, DS_STATUS, DS_STEP, DS_SKIP
    } qp_dev_state_t;
    typedef enum logic [2:0] {
        HS_IDLE, HS_LOW, HS_HIGH, HS_TRAIL, HS_GAP
    } qp_host_state_t;
endpackage
`default_nettype wire

// *** rtl/qp_pot_dev.sv ***
// Purpose: Serial command decoder of a quad digital potentiometer.
// Assumes: Frame logic runs on the link clock; write timer on i_clk_sys.
// Notes: Chip select high resets the frame logic.
// Functional notes
// R01: Write data register stores the data byte.
// R02: Status read returns zeros and busy flag.
// R03: Global transfer loads all wipers from slot.
// R04: Global wiper store uses nonvolatile write.
// R05: Single wiper store uses nonvolatile write.
// R06: Single transfer loads wiper from slot.
// R07: Step command moves wiper per clocked bit.
// R08: Nonvolatile write starts after chip select rises.
// R09: High bit steps up, low steps down.
// R10: Nonvolatile write lasts at least write time.
// R11: Ignore frames with wrong type or address.
// R12: No new write while busy; host polls.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`include "qp_defs.svh"
`default_nettype none
module qp_pot_dev
    import qp_pkg::*;
#(
    parameter int P_TWR_CYC = (`QP_TWR_NS + `QP_CLK_NS - 1) / `QP_CLK_NS
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [1:0] i_chip_addr,
    qp_link_if.dev link,
    output logic [23:0] o_wiper,
    output logic o_wip
);
    // ------------------------------------------------------------------
    // Link clock domain: frame decode
    // ------------------------------------------------------------------
    qp_dev_state_t state;
    qp_dev_state_t next_state;
    logic [4:0] cnt;
    logic [6:0] rx;
    logic [1:0] cmd_slot;
    logic [1:0] cmd_pot;
    logic [7:0] tx_sh;
    logic [1:0] addr_s1;
    logic [1:0] addr_s2;
    logic wip_s1;
    logic wip_s2;
    logic so_q;
    logic so_oe_q;
    qp_wiper_t wiper_setting_reg [`QP_POTS];
    qp_wiper_t next_wcr [`QP_POTS];
    qp_wiper_t dr [`QP_POTS][4];
    logic pend_tgl;
    logic [1:0] pend_slot;
    logic [3:0] pend_mask;
    qp_wiper_t pend_val [`QP_POTS];

    // A high chip select holds the frame logic in reset, since the link
    // clock stands still between frames.
    wire logic frame_rstn = i_rstn & ~link.cs_n;
    wire logic [7:0] in_byte = {rx, link.si};
    wire logic at_byte = cnt[2:0] == 3'h7;
    wire logic [3:0] op = in_byte[7:4];
    wire logic [1:0] slot = in_byte[3:2];
    wire logic [1:0] pot = in_byte[1:0];
    wire logic addr_ok = in_byte[7:2] == `QP_DEV_TYPE && pot == addr_s2; // [R11]
    wire logic instr_edge = state == DS_INSTR && at_byte;
    wire logic load_one = instr_edge && op == `QP_OP_D2W; // [R06]
    wire logic load_all = instr_edge && op == `QP_OP_GD2W && pot == 2'h0; // [R03]
    wire logic pend_one = instr_edge && op == `QP_OP_W2D && !wip_s2; // [R05] [R12]
    wire logic pend_all = instr_edge && op == `QP_OP_GW2D && pot == 2'h0
        && !wip_s2; // [R04] [R12]
    wire logic pend_data = state == DS_WDATA && at_byte; // [R01]
    wire logic pend_any = pend_one || pend_all || pend_data;
    wire logic [1:0] pend_pot = pend_data ? cmd_pot : pot;
    wire logic is_status = instr_edge && in_byte == `QP_INS_STATUS;

    always_comb begin
        next_state = state;
        case (state)
            DS_ADDR: begin
                if (at_byte) begin
                    next_state = addr_ok ? DS_INSTR : DS_SKIP; // [R11]
                end
            end
            DS_INSTR: begin
                if (at_byte) begin
                    next_state = DS_SKIP;
                    if (op == `QP_OP_WDR && !wip_s2) begin
                        next_state = DS_WDATA; // [R01] [R12]
                    end else if (in_byte == `QP_INS_STATUS) begin
                        next_state = DS_STATUS; // [R02]
                    end else if (op == `QP_OP_STEP && slot == 2'h0) begin
                        next_state = DS_STEP; // [R07]
                    end
                end
            end
            DS_WDATA, DS_STATUS: begin
                if (at_byte) begin
                    next_state = DS_SKIP;
                end
            end
            DS_STEP: next_state = DS_STEP;
            DS_SKIP: next_state = DS_SKIP;
            default: next_state = DS_SKIP;
        endcase
    end

    always_ff @(posedge link.sck or negedge frame_rstn) begin
        if (!frame_rstn) begin
            state <= DS_ADDR;
            cnt <= 5'h00;
            rx <= 7'h00;
        end else begin
            state <= next_state;
            rx <= in_byte[6:0];
            if (cnt != 5'h1F) begin
                cnt <= cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge link.sck or negedge frame_rstn) begin
        if (!frame_rstn) begin
            cmd_slot <= 2'h0;
            cmd_pot <= 2'h0;
            tx_sh <= 8'h00;
        end else begin
            if (instr_edge) begin
                cmd_slot <= slot;
                cmd_pot <= pot;
            end
            if (is_status) begin
                tx_sh <= {7'h00, wip_s2}; // [R02]
            end else if (state == DS_STATUS) begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // Data out changes on the falling edge so the host samples a settled bit.
    always_ff @(negedge link.sck or negedge frame_rstn) begin
        if (!frame_rstn) begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            so_q <= tx_sh[7]; // [R02]
            so_oe_q <= state == DS_STATUS;
        end
    end
    assign link.so = so_q;
    assign link.so_oe = so_oe_q;

    // Straps and the busy flag come from other domains.
    always_ff @(posedge link.sck or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_s1 <= 2'h0;
            addr_s2 <= 2'h0;
            wip_s1 <= 1'b0;
            wip_s2 <= 1'b0;
        end else begin
            addr_s1 <= i_chip_addr;
            addr_s2 <= addr_s1;
            wip_s1 <= o_wip;
            wip_s2 <= wip_s1;
        end
    end

    // ------------------------------------------------------------------
    // Wiper registers and pending store
    // ------------------------------------------------------------------
    for (genvar p = 0; p < `QP_POTS; p++) begin : g_wcr
        wire logic sel = (load_all || (load_one && pot == 2'(p)));
        wire logic stp = state == DS_STEP && cmd_pot == 2'(p);
        wire qp_wiper_t up = wiper_setting_reg[p] == `QP_WIPER_MAX ? wiper_setting_reg[p] : wiper_setting_reg[p] + 6'h01;
        wire qp_wiper_t dn = wiper_setting_reg[p] == 6'h00 ? wiper_setting_reg[p] : wiper_setting_reg[p] - 6'h01;
        // Transfers read storage written in the system domain; it only
        // changes at the end of a write cycle, while the host polls.
        assign next_wcr[p] = sel ? dr[p][slot] : stp ? (link.si ? up : dn)
            : wiper_setting_reg[p]; // [R03] [R06] [R07] [R09]
        assign o_wiper[p * 6 +: 6] = wiper_setting_reg[p];
        always_ff @(posedge link.sck or negedge i_rstn) begin
            if (!i_rstn) begin
                wiper_setting_reg[p] <= `QP_WCR_RST;
                pend_val[p] <= `QP_DR_RST;
            end else begin
                wiper_setting_reg[p] <= next_wcr[p];
                if (pend_any) begin
                    pend_val[p] <= pend_data ? in_byte[5:0] : wiper_setting_reg[p]; // [R01] [R04] [R05]
                end
            end
        end
    end

    always_ff @(posedge link.sck or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_tgl <= 1'b0;
            pend_slot <= 2'h0;
            pend_mask <= 4'h0;
        end else if (pend_any) begin
            pend_tgl <= ~pend_tgl;
            pend_slot <= pend_data ? cmd_slot : slot;
            pend_mask <= pend_all ? 4'hF : 4'(4'h1 << pend_pot);
        end
    end

    // ------------------------------------------------------------------
    // System clock domain: write cycle
    // ------------------------------------------------------------------
    logic cs_s1;
    logic cs_s2;
    logic pt_s1;
    logic pt_s2;
    logic pend_ack;
    logic [23:0] twr_cnt;

    // The pending payload is stable here: it was set on the same link edge as the toggle and
    // no link edge arrives while chip select is high.
    wire logic nv_start = cs_s2 && pt_s2 != pend_ack && !o_wip; // [R08] [R12]
    wire logic nv_done = o_wip && twr_cnt == 24'h00_0000;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            pt_s1 <= 1'b0;
            pt_s2 <= 1'b0;
            pend_ack <= 1'b0;
            o_wip <= 1'b0;
            twr_cnt <= 24'h00_0000;
        end else begin
            cs_s1 <= link.cs_n;
            cs_s2 <= cs_s1;
            pt_s1 <= pend_tgl;
            pt_s2 <= pt_s1;
            if (nv_start) begin
                pend_ack <= pt_s2;
                o_wip <= 1'b1;
                twr_cnt <= 24'(P_TWR_CYC - 1); // [R10]
            end else if (nv_done) begin
                o_wip <= 1'b0;
            end else if (o_wip) begin
                twr_cnt <= twr_cnt - 24'h00_0001;
            end
        end
    end

    // Storage commits at the end of the cycle, as the cell would.
    for (genvar p = 0; p < `QP_POTS; p++) begin : g_dr
        for (genvar s = 0; s < 4; s++) begin : g_slot
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    dr[p][s] <= `QP_DR_RST;
                end else if (nv_done && pend_mask[p] && pend_slot == 2'(s)) begin
                    dr[p][s] <= pend_val[p]; // [R10]
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/qp_link_assertions.sv ***
// Purpose: Concurrent checks on the quad pot serial link.
// Assumes: cs_n, sck and si are flops of the system clock domain; so and so_oe are flops on the link clock edges.
// Notes: Instantiated beside the link interface, no bind.
`default_nettype none
module qp_link_assertions #(
    parameter int P_TWR_CYC = 2000
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_so,
    input wire logic i_so_oe,
    input wire logic i_wip
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    logic sck_q;
    logic [7:0] rises;
    logic [23:0] wip_cnt;
    logic [4:0] gap;
    // The gap counter starts saturated so the first frame after reset is legal.
    // The busy counter is as wide as the device's write timer.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            sck_q <= 1'b0;
            rises <= 8'h00;
            wip_cnt <= 24'h00_0000;
            gap <= 5'h1F;
        end else begin
            sck_q <= i_sck;
            rises <= i_cs_n ? 8'h00 : rises + {7'h00, i_sck & ~sck_q};
            wip_cnt <= i_wip ? wip_cnt + 24'h00_0001 : 24'h00_0000;
            gap <= !i_cs_n ? 5'h00 : (gap == 5'h1F) ? gap : gap + 5'h01;
        end
    end
    sck_idle_a: assert property (i_cs_n |-> !i_sck)
        else $error("link clock moved outside a frame");
    si_hold_a: assert property ($rose(i_sck) |-> $stable(i_si))
        else $error("serial input changed at a clock rise");
    frame_len_a: assert property ($rose(i_cs_n) |-> rises >= 8'h10)
        else $error("frame ended before two bytes");
    cs_gap_a: assert property ($fell(i_cs_n) |-> gap >= 5'h10)
        else $error("chip select high time too short");
    oe_frame_a: assert property (i_so_oe |-> !i_cs_n)
        else $error("output enabled outside a frame");
    oe_start_a: assert property ($rose(i_so_oe) |-> rises == 8'h10)
        else $error("status byte started at the wrong bit");
    status_zero_a: assert property ($rose(i_sck) && i_so_oe && rises < 8'h17 |-> !i_so)
        else $error("status upper bits not zero");
    wip_late_a: assert property ($rose(i_wip) |-> $past(i_cs_n) && $past(i_cs_n, 2))
        else $error("write cycle began before chip select rose");
    wip_len_a: assert property ($fell(i_wip) |-> wip_cnt >= P_TWR_CYC)
        else $error("write cycle too short");
    cover property ($rose(i_wip));
    cover property ($rose(i_so_oe));
    cover property ($rose(i_cs_n) && rises > 8'h10 && rises != 8'h18);
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: Self-checking bench joining controller and pot device.
// Assumes: 125 MHz clock; short write cycle via parameter.
// Notes: Software orders frames over AXI4-Lite and polls busy.
`include "qp_defs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TWR = 2000;
    localparam logic [1:0] ME = 2'h1;
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [1:0] chip_addr = ME;
    logic awready, wready, bvalid, arready, rvalid, write_progress_status;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [23:0] wiper;
    logic [23:0] exp_w = 24'h0;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    qp_link_if link();
    qp_host qp_host_inst(.i_clk_sys(clk), .i_rstn(rstn), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .link(link.host));
    qp_pot_dev #(.P_TWR_CYC(TWR)) qp_pot_dev_inst(.i_clk_sys(clk), .i_rstn(rstn),
        .i_chip_addr(chip_addr), .link(link.dev), .o_wiper(wiper), .o_wip(write_progress_status));
    qp_link_assertions #(.P_TWR_CYC(TWR)) qp_link_assertions_inst(.i_clk_sys(clk),
        .i_rstn(rstn), .i_cs_n(link.cs_n), .i_sck(link.sck), .i_si(link.si),
        .i_so(link.so), .i_so_oe(link.so_oe), .i_wip(write_progress_status));
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Sends one frame and waits until the controller is idle again.
    task automatic cmd(input logic [7:0] ins, input logic [7:0] d, input logic [1:0] c,
        input logic [3:0] n, output logic [7:0] st);
        logic [31:0] rd;
        logic [1:0] r;
        axi_wr(8'h00, {4'h0, n, 6'h00, c, d, ins}, r);
        chk("bresp", 32'h0, {30'h0, r});
        rd = 32'h1;
        while (rd[0]) axi_rd(8'h04, rd, r);
        st = rd[15:8];
    endtask
    task automatic nv_wait;
        logic [7:0] st;
        st = 8'h01;
        while (st[0]) cmd(`QP_INS_STATUS, 8'h00, ME, 4'h8, st);
        chk("status", 32'h0, {24'h0, st});
    endtask
    task automatic t_regs;
        logic [31:0] rd;
        logic [1:0] r;
        axi_rd(8'h04, rd, r);
        chk("stat", 32'h0, rd);
        axi_rd(8'h08, rd, r);
        chk("rresp", 32'h2, {30'h0, r});
        chk("rdata", 32'h0, rd);
        axi_wr(8'h04, 32'h1, r);
        chk("bresp ro", 32'h2, {30'h0, r});
    endtask
    task automatic t_wdata;
        logic [7:0] st;
        cmd({`QP_OP_WDR, 2'h1, 2'h2}, 8'hE5, ME, 4'h8, st);
        cmd(`QP_INS_STATUS, 8'h00, ME, 4'h8, st);
        chk("status busy", 32'h1, {24'h0, st});
        cmd({`QP_OP_WDR, 2'h1, 2'h2}, 8'h0A, ME, 4'h8, st);
        nv_wait();
        cmd({`QP_OP_D2W, 2'h1, 2'h2}, 8'h00, ME, 4'h0, st);
        exp_w[17:12] = 6'h25;
        chk("wiper", {8'h0, exp_w}, {8'h0, wiper});
    endtask
    task automatic t_step;
        logic [7:0] st;
        cmd({`QP_OP_STEP, 2'h0, 2'h2}, 8'hFF, ME, 4'h8, st);
        exp_w[17:12] = 6'h2D;
        chk("step up", {8'h0, exp_w}, {8'h0, wiper});
        cmd({`QP_OP_STEP, 2'h0, 2'h2}, 8'h1F, ME, 4'h3, st);
        exp_w[17:12] = 6'h2A;
        chk("step down", {8'h0, exp_w}, {8'h0, wiper});
        cmd({`QP_OP_STEP, 2'h0, 2'h0}, 8'h00, ME, 4'h8, st);
        chk("step floor", {8'h0, exp_w}, {8'h0, wiper});
    endtask
    task automatic t_xfer;
        logic [7:0] st;
        cmd({`QP_OP_W2D, 2'h3, 2'h2}, 8'h00, ME, 4'h0, st);
        nv_wait();
        cmd({`QP_OP_STEP, 2'h0, 2'h2}, 8'hFF, ME, 4'h8, st);
        cmd({`QP_OP_STEP, 2'h0, 2'h1}, 8'hFF, ME, 4'h8, st);
        cmd({`QP_OP_GD2W, 2'h3, 2'h0}, 8'h00, ME, 4'h0, st);
        chk("global load", {8'h0, exp_w}, {8'h0, wiper});
        cmd({`QP_OP_GW2D, 2'h2, 2'h0}, 8'h00, ME, 4'h0, st);
        nv_wait();
        cmd({`QP_OP_STEP, 2'h0, 2'h2}, 8'h00, ME, 4'h3, st);
        cmd({`QP_OP_D2W, 2'h2, 2'h2}, 8'h00, ME, 4'h0, st);
        chk("global store", {8'h0, exp_w}, {8'h0, wiper});
    endtask
    task automatic t_addr;
        logic [7:0] st;
        logic [31:0] rd;
        logic [1:0] r;
        cmd({`QP_OP_STEP, 2'h0, 2'h2}, 8'hFF, 2'h2, 4'h8, st);
        chk("foreign step", {8'h0, exp_w}, {8'h0, wiper});
        cmd({`QP_OP_WDR, 2'h0, 2'h0}, 8'h11, 2'h3, 4'h8, st);
        chk("foreign write", 32'h0, {31'h0, write_progress_status});
        axi_rd(8'h00, rd, r);
        chk("cmd readback", 32'h0803_11C0, rd);
    endtask
    // A hang is cut short well above the expected run length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Reset falls from its initial high value at time zero so that the link-clocked flops, which see
    // no clock edge while reset is held, still catch a falling reset edge.
    initial begin
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_wdata();
        t_step();
        t_xfer();
        t_addr();
        wrap_up();
    end
endmodule
`default_nettype wire
